// file: itot_defines.svh
// Purpose: constants of the inverse-time overcurrent timer
// Assumes: 16-bit multiple of pickup in 8.8 fixed point
// Notes:   coefficients are kept in units of 1/10000
`ifndef ITOT_DEFINES_SVH
`define ITOT_DEFINES_SVH
`define ITOT_CFG_OFS     8'h00
`define ITOT_STAT_OFS    8'h0C
`define ITOT_MASK_OFS    8'h10
`define ITOT_LIVE_OFS    8'h14
`define ITOT_TRAV_OFS    8'h18
`define ITOT_CURVE_LSB   0
`define ITOT_DLY_BIT     2
`define ITOT_TD_LSB      16
`define ITOT_TD_RST      12'h100
`define ITOT_MASK_RST    7'h00
`define ITOT_EV_RST_LSB  3
`define ITOT_EV_OVR_BIT  6
`define ITOT_PICK_LSB    3
`define ITOT_LINE_HZ     60
`define ITOT_SMP_PER_CYC 16
`define ITOT_SMP_PER_S   (`ITOT_LINE_HZ * `ITOT_SMP_PER_CYC)
`define ITOT_TRAV_FS     24
`define ITOT_TRAV_FULL   (32'h1 << `ITOT_TRAV_FS)
`define ITOT_OP_NUM      ((64'h1 << (`ITOT_TRAV_FS + 24)) / `ITOT_SMP_PER_S)
`define ITOT_ONE         16'h0100
`define ITOT_DIV_STEPS   7'h40
`define ITOT_COEF_DEN    10000
`define ITOT_C1_A        1570
`define ITOT_C1_B        6680
`define ITOT_C1_C        9490
`define ITOT_C1_K        9360
`define ITOT_C2_A        1800
`define ITOT_C2_B        59500
`define ITOT_C2_C        1720
`define ITOT_C2_K        1680
`define ITOT_C3_A        963
`define ITOT_C3_B        38800
`define ITOT_C3_C        2460
`define ITOT_C3_K        2400
`define ITOT_C4_A        352
`define ITOT_C4_B        56700
`define ITOT_C4_C        1940
`define ITOT_C4_K        1920
`endif

// file: itot_pkg.sv
// Purpose: types of the inverse-time overcurrent timer
// Assumes: nothing
// Notes:   constants live in itot_defines.svh
package itot_pkg;
  typedef enum logic [1:0] {
    ITOT_MOD_INV  = 2'h0,
    ITOT_INV      = 2'h1,
    ITOT_VERY_INV = 2'h2,
    ITOT_EXT_INV  = 2'h3
  } itot_curve_t;
  typedef struct packed {
    logic [11:0] time_dial;
    logic        delayed;
    itot_curve_t curve;
  } itot_cfg_t;
  typedef struct packed {
    logic        above;
    logic [63:0] dividend;
    logic [63:0] divisor;
  } itot_job_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CALC = 5'h02,
    ST_LOAD = 5'h04,
    ST_WAIT = 5'h08,
    ST_UPD  = 5'h10
  } itot_state_t;
endpackage

// file: itot_curve.sv
// Purpose: travel-rate division job for one element and one sample
// Assumes: m_i in 8.8 fixed point, time dial in 4.8 fixed point
// Notes:   rate = dividend / divisor, one divide per sample
`timescale 1ns/1ps
`include "itot_defines.svh"
module itot_curve (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic [15:0]         m_i,
  input  wire itot_pkg::itot_cfg_t cfg_i,
  output itot_pkg::itot_job_t      job_o
);
  function automatic logic [19:0] q16(input int x);
    q16 = 20'((64'(x) * 64'h10000 + 64'(`ITOT_COEF_DEN / 2))
              / `ITOT_COEF_DEN);
  endfunction
  localparam logic [19:0] A_Q [4] = '{q16(`ITOT_C1_A), q16(`ITOT_C2_A),
                                      q16(`ITOT_C3_A), q16(`ITOT_C4_A)};
  localparam logic [19:0] B_Q [4] = '{q16(`ITOT_C1_B), q16(`ITOT_C2_B),
                                      q16(`ITOT_C3_B), q16(`ITOT_C4_B)};
  localparam logic [19:0] C_Q [4] = '{q16(`ITOT_C1_C), q16(`ITOT_C2_C),
                                      q16(`ITOT_C3_C), q16(`ITOT_C4_C)};
  localparam logic [19:0] K_Q [4] = '{q16(`ITOT_C1_K), q16(`ITOT_C2_K),
                                      q16(`ITOT_C3_K), q16(`ITOT_C4_K)};
  wire [1:0]  c     = cfg_i.curve;
  wire        above = m_i > `ITOT_ONE;
  wire [31:0] msq   = 32'(m_i) * 32'(m_i);
  wire [23:0] d_lin = {8'h00, m_i} - {8'h00, `ITOT_ONE};
  wire [23:0] d_sq  = msq[31:8] - {8'h00, `ITOT_ONE};
  // curve 1 divides by M-1, the others by M squared minus 1
  wire [23:0] d     = (c == 2'h0) ? d_lin : d_sq;
  // t/Ts = td*(A*d+B)/d, so one division gives the rate
  wire [44:0] s     = 45'(A_Q[c]) * 45'(d) + {17'h0, B_Q[c], 8'h00};
  wire [56:0] dv_op = 57'(cfg_i.time_dial) * 57'(s);
  // reset slope stays positive for M <= 1 on every curve
  wire [35:0] r     = {8'h00, C_Q[c], 8'h00} - 36'(K_Q[c]) * 36'(m_i);
  itot_pkg::itot_job_t next_job;
  assign next_job.above    = above;
  assign next_job.dividend = above ? 64'(d) * `ITOT_OP_NUM
                                   : 64'(r[23:0]) * `ITOT_OP_NUM;
  assign next_job.divisor  = above ? {7'h00, dv_op}
                                   : {12'h000, cfg_i.time_dial, 40'h0};
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      job_o <= '0;
    end else if (ce_i) begin
      job_o <= next_job;
    end
  end
  property p_above_op;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && m_i > `ITOT_ONE) |=> job_o.above;
  endproperty
  a_above_op: assert property (p_above_op)
    else $error("operating formula not chosen above pickup");
  property p_below_rst;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && m_i <= `ITOT_ONE)
      |=> !job_o.above && job_o.divisor[39:0] == 40'h0;
  endproperty
  a_below_rst: assert property (p_below_rst)
    else $error("reset formula not chosen at or below pickup");
endmodule // itot_curve

// file: itot_div.sv
// Purpose: 64-bit restoring divider, one quotient bit per cycle
// Assumes: start_i only while idle
// Notes:   zero divisor yields an all-ones quotient
`timescale 1ns/1ps
`include "itot_defines.svh"
module itot_div (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic [63:0] dividend_i,
  input  wire logic [63:0] divisor_i,
  output logic             done_o,
  output logic [63:0]      quot_o
);
  logic [63:0] rem;
  logic [63:0] dvs;
  logic [63:0] dvd_keep;
  logic [6:0]  cnt;
  logic        busy;
  wire  [64:0] trial = {rem, quot_o[63]};
  wire         ge    = trial >= {1'b0, dvs};
  wire  [64:0] diff  = trial - {1'b0, dvs};
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rem <= '0; dvs <= '0; dvd_keep <= '0; quot_o <= '0;
      cnt <= '0; busy <= 1'b0; done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        quot_o <= dividend_i; dvd_keep <= dividend_i;
        dvs <= divisor_i; rem <= '0;
        cnt <= `ITOT_DIV_STEPS; busy <= 1'b1;
      end else if (busy) begin
        rem    <= ge ? diff[63:0] : trial[63:0];
        quot_o <= {quot_o[62:0], ge};
        cnt    <= cnt - 7'h01;
        if (cnt == 7'h01) begin
          busy   <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
  property p_quot;
    @(posedge core_clk_i) disable iff (rst_i)
    (done_o && dvs != 64'h0) |->
      128'(quot_o) * 128'(dvs) <= 128'(dvd_keep) &&
      128'(dvd_keep) - 128'(quot_o) * 128'(dvs) < 128'(dvs);
  endproperty
  a_quot: assert property (p_quot)
    else $error("travel rate quotient is wrong");
endmodule // itot_div

// file: itot_timer.sv
// Purpose: inverse-time overcurrent timing for three elements
// Assumes: samples at 960 per second, spaced over 210 clock cycles
// Notes:   one shared curve path and divider serve all elements
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "itot_defines.svh"
// Function
// - All three elements use the same curve and reset arithmetic.
// - Each element has its own fast or delayed reset selection.
// - Fast reset zeroes travel after one cycle below pickup.
// - Delayed reset time uses dial, travel and current level.
// - Operating formula above pickup, reset formula at or below.
// - Curve 1 operating and reset formulas, moderately inverse.
// - Curve 2 operating and reset formulas, inverse.
// - Curve 3 operating and reset formulas, very inverse.
// - Curve 4 operating and reset formulas, extremely inverse.
module itot_timer (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        sample_stb_i,
  input  wire logic [15:0] phase_mop_i,
  input  wire logic [15:0] negseq_mop_i,
  input  wire logic [15:0] ground_mop_i,
  output logic [2:0]       trip_o,
  output logic             irq_o
);
  localparam int         NEL  = 3;
  localparam logic [4:0] SPC  = 5'(`ITOT_SMP_PER_CYC);
  localparam logic [31:0] FULL = `ITOT_TRAV_FULL;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  itot_pkg::itot_state_t st;
  itot_pkg::itot_state_t next_st;
  itot_pkg::itot_cfg_t   cfg  [NEL];
  itot_pkg::itot_job_t   job;
  logic [1:0]            elem;
  logic [15:0]           smp  [NEL];
  logic [31:0]           trav [NEL];
  logic [4:0]            blw  [NEL];
  logic [NEL-1:0]        trip;
  logic [6:0]            stat;
  logic [6:0]            mask;
  logic                  cap_ok;
  logic                  div_done;
  logic [63:0]           quot;

  // per-element reset selections
  wire phase_reset_select  = cfg[0].delayed;
  wire negseq_reset_select = cfg[1].delayed;
  wire ground_reset_select = cfg[2].delayed;
  wire [NEL-1:0] dly_sel = {ground_reset_select,
                            negseq_reset_select,
                            phase_reset_select};

  // APB slave: read data captured while psel is high
  assign pready_o = ce_i & cap_ok & psel_i & penable_i;
  wire bus_acc = psel_i & penable_i & pready_o;
  wire wr_en   = bus_acc & pwrite_i;
  wire rd_en   = bus_acc & ~pwrite_i;

  wire [NEL-1:0] cfg_hit;
  wire [NEL-1:0] trav_hit;
  wire [31:0]    cfg_word [NEL];
  wire stat_hit = hit(paddr_i, `ITOT_STAT_OFS);
  wire mask_hit = hit(paddr_i, `ITOT_MASK_OFS);
  wire live_hit = hit(paddr_i, `ITOT_LIVE_OFS);
  wire mapped   = (|cfg_hit) | (|trav_hit) | stat_hit
                | mask_hit | live_hit;

  genvar g;
  generate
    for (g = 0; g < NEL; g++) begin : g_dec
      assign cfg_hit[g]  = hit(paddr_i, `ITOT_CFG_OFS + 8'(4 * g));
      assign trav_hit[g] = hit(paddr_i, `ITOT_TRAV_OFS + 8'(4 * g));
      assign cfg_word[g] =
        (32'(cfg[g].time_dial) << `ITOT_TD_LSB)
        | (32'(cfg[g].delayed) << `ITOT_DLY_BIT)
        | (32'(cfg[g].curve) << `ITOT_CURVE_LSB);
    end
  endgenerate

  // live view of the trip levels
  wire [31:0] live_word = {29'h0, trip};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    for (int i = 0; i < NEL; i++) begin
      if (cfg_hit[i]) rd_mux = rd_mux | cfg_word[i];
      if (trav_hit[i]) rd_mux = rd_mux | trav[i];
    end
    if (stat_hit) rd_mux = rd_mux | {25'h0, stat};
    if (mask_hit) rd_mux = rd_mux | {25'h0, mask};
    if (live_hit) rd_mux = rd_mux | live_word;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
      cap_ok    <= 1'b0;
    end else if (ce_i) begin
      cap_ok <= psel_i & ~(penable_i & pready_o);
      if (psel_i) begin
        prdata_o  <= rd_mux;
        pslverr_o <= ~mapped;
      end
    end
  end

  // sequencer: one element at a time through curve and divider
  wire busy  = (st != itot_pkg::ST_IDLE);
  wire start = (st == itot_pkg::ST_IDLE) & sample_stb_i;
  always_comb begin
    next_st = st;
    unique case (st)
      itot_pkg::ST_IDLE: begin
        if (sample_stb_i) next_st = itot_pkg::ST_CALC;
      end
      itot_pkg::ST_CALC: begin
        next_st = itot_pkg::ST_LOAD;
      end
      itot_pkg::ST_LOAD: begin
        next_st = itot_pkg::ST_WAIT;
      end
      itot_pkg::ST_WAIT: begin
        if (div_done) next_st = itot_pkg::ST_UPD;
      end
      itot_pkg::ST_UPD: begin
        next_st = (elem == 2'(NEL - 1)) ? itot_pkg::ST_IDLE
                                        : itot_pkg::ST_CALC;
      end
      default: begin
        next_st = itot_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st   <= itot_pkg::ST_IDLE;
      elem <= 2'h0;
    end else if (ce_i) begin
      st <= next_st;
      if (start) elem <= 2'h0;
      else if (st == itot_pkg::ST_UPD && elem != 2'(NEL - 1))
        elem <= elem + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      smp <= '{default: 16'h0};
    end else if (ce_i && start) begin
      smp[0] <= phase_mop_i;
      smp[1] <= negseq_mop_i;
      smp[2] <= ground_mop_i;
    end
  end

  // shared arithmetic, steered by the element index
  itot_curve u_curve (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .m_i        (smp[elem]),
    .cfg_i      (cfg[elem]),
    .job_o      (job)
  );

  itot_div u_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .start_i    (st == itot_pkg::ST_LOAD),
    .dividend_i (job.dividend),
    .divisor_i  (job.divisor),
    .done_o     (div_done),
    .quot_o     (quot)
  );

  // travel update for the element in hand
  wire [31:0] cur   = trav[elem];
  wire [31:0] inc   = (|quot[63:32]) ? 32'hFFFF_FFFF : quot[31:0];
  wire [32:0] sum   = {1'b0, cur} + {1'b0, inc};
  wire [31:0] up    = (sum >= {1'b0, FULL}) ? FULL : sum[31:0];
  wire [31:0] dn    = (cur > inc) ? cur - inc : 32'h0;
  wire        fdone = blw[elem] >= SPC - 5'h01;
  wire [31:0] next_trav = job.above ? up
                        : dly_sel[elem] ? dn
                        : fdone ? 32'h0 : cur;
  wire        next_trip = next_trav >= FULL;
  wire [4:0]  next_blw  = job.above ? 5'h00
                        : (blw[elem] == SPC) ? SPC
                        : blw[elem] + 5'h01;

  wire [NEL-1:0] upd_sel;
  wire [NEL-1:0] ev_trip;
  wire [NEL-1:0] ev_rst;
  generate
    for (g = 0; g < NEL; g++) begin : g_el
      assign upd_sel[g] = (st == itot_pkg::ST_UPD) && (elem == 2'(g));
      assign ev_trip[g] = upd_sel[g] & next_trip & ~trip[g];
      assign ev_rst[g]  = upd_sel[g] & (cur != 32'h0)
                        & (next_trav == 32'h0);
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          trav[g] <= 32'h0;
          blw[g]  <= 5'h00;
          trip[g] <= 1'b0;
        end else if (ce_i && upd_sel[g]) begin
          trav[g] <= next_trav;
          blw[g]  <= next_blw;
          trip[g] <= next_trip;
        end
      end
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          cfg[g] <= '{time_dial: `ITOT_TD_RST, delayed: 1'b0,
                      curve: itot_pkg::ITOT_MOD_INV};
        end else if (ce_i && wr_en && cfg_hit[g]) begin
          cfg[g].time_dial <= pwdata_i[`ITOT_TD_LSB +: 12];
          cfg[g].delayed   <= pwdata_i[`ITOT_DLY_BIT];
          cfg[g].curve     <=
            itot_pkg::itot_curve_t'(pwdata_i[`ITOT_CURVE_LSB +: 2]);
        end
      end
    end
  endgenerate
  assign trip_o = trip;

  // events: a new event wins over a read clear in the same cycle
  wire [6:0] ev = {sample_stb_i & busy, ev_rst, ev_trip};
  wire [6:0] clr = (rd_en && stat_hit) ? prdata_o[6:0] : 7'h00;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat <= 7'h00;
      mask <= `ITOT_MASK_RST;
    end else if (ce_i) begin
      stat <= (stat & ~clr) | ev;
      if (wr_en && mask_hit) mask <= pwdata_i[6:0];
    end
  end
  assign irq_o = |(stat & mask);

  property p_trip_flag;
    @(posedge core_clk_i) disable iff (rst_i)
    trip[0] == (trav[0] >= FULL);
  endproperty
  a_trip_flag: assert property (p_trip_flag)
    else $error("trip does not match full travel");
  property p_trav_cap;
    @(posedge core_clk_i) disable iff (rst_i)
    trav[0] <= FULL && trav[2] <= FULL;
  endproperty
  a_trav_cap: assert property (p_trav_cap)
    else $error("travel beyond full scale");
  property p_op_rise;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && upd_sel[0] && job.above)
      |=> trav[0] >= $past(trav[0]) && blw[0] == 5'h00;
  endproperty
  a_op_rise: assert property (p_op_rise)
    else $error("travel fell above pickup");
  property p_fast;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && upd_sel[0] && !job.above && !dly_sel[0]
     && blw[0] >= SPC - 5'h01) |=> trav[0] == 32'h0 && !trip[0];
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast reset did not clear travel");
  property p_fast_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && upd_sel[1] && !job.above && !dly_sel[1]
     && blw[1] < SPC - 5'h01) |=> trav[1] == $past(trav[1]);
  endproperty
  a_fast_hold: assert property (p_fast_hold)
    else $error("fast reset acted before one cycle");
  property p_dly_dec;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && upd_sel[1] && !job.above && dly_sel[1])
      |=> trav[1] < $past(trav[1]) || trav[1] == 32'h0;
  endproperty
  a_dly_dec: assert property (p_dly_dec)
    else $error("delayed reset raised travel");
  property p_all_elem;
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && upd_sel[0]) |=> st == itot_pkg::ST_CALC && elem == 2'h1
      ##[1:200] upd_sel[2];
  endproperty
  a_all_elem: assert property (p_all_elem)
    else $error("elements not all processed");
  c_trip: cover property (@(posedge core_clk_i) disable iff (rst_i)
    ev_trip[0]);
  c_fast: cover property (@(posedge core_clk_i) disable iff (rst_i)
    ev_rst[0] && !dly_sel[0]);
  c_dly: cover property (@(posedge core_clk_i) disable iff (rst_i)
    upd_sel[1] && dly_sel[1] && !job.above);
  c_irq: cover property (@(posedge core_clk_i) disable iff (rst_i)
    irq_o && rd_en && stat_hit);
endmodule // itot_timer

// file: tb_itot_timer.sv
// Purpose: self-checking bench of the overcurrent timer
// Assumes: zero or one wait state on the register bus
// Notes:   travel figures compared within a small tolerance
`timescale 1ns/1ps
module tb_itot_timer;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] msk;
    logic [31:0] tol;
    logic        err;
  } itot_tb_note_t;

  localparam logic [31:0] FULL = 32'h01000000;
  localparam logic [31:0] ALL  = 32'hFFFFFFFF;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stb = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] pm = 16'h0000;
  logic [15:0] qm = 16'h0000;
  logic [15:0] gm = 16'h0000;
  logic [2:0]  trip;
  logic        irq;
  int          failures = 0;
  int          checks_done = 0;
  int          seed = 46;
  itot_tb_note_t notes[$];

  itot_timer u_itot_timer (
    .core_clk_i   (clk),
    .rst_i        (rst),
    .ce_i         (ce),
    .psel_i       (psel),
    .penable_i    (penable),
    .pwrite_i     (pwrite),
    .paddr_i      (paddr),
    .pwdata_i     (pwdata),
    .prdata_o     (prdata),
    .pready_o     (pready),
    .pslverr_o    (pslverr),
    .sample_stb_i (stb),
    .phase_mop_i  (pm),
    .negseq_mop_i (qm),
    .ground_mop_i (gm),
    .trip_o       (trip),
    .irq_o        (irq)
  );

  always #5 clk = ~clk;

  task automatic fail(input string msg);
    failures++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp) begin
      fail(msg);
    end
  endtask

  // every transfer leaves a note; the monitor below judges it
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input itot_tb_note_t n);
    int k;
    notes.push_back(n);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      fail("bus wait ran out");
      wrap_up();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [31:0] t);
    apb(1'b0, a, 32'h0, '{exp: e, msk: m, tol: t, err: 1'b0});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '{exp: 32'h0, msk: 32'h0, tol: 32'h0, err: 1'b0});
  endtask

  always @(posedge clk) begin
    itot_tb_note_t n;
    logic [32:0]   got;
    logic          ok;
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        fail("transfer without note");
      end else begin
        n   = notes.pop_front();
        got = {1'b0, prdata & n.msk};
        ok  = (got + n.tol >= n.exp) && (got <= n.exp + n.tol);
        checks_done++;
        if (ok !== 1'b1 || pslverr !== n.err) begin
          fail("bus answer differs");
        end
      end
    end
  end

  // one sample; spacing keeps to the 210-cycle minimum
  task automatic samp(input logic [15:0] p, q, g);
    @(posedge clk);
    stb <= 1'b1;
    pm  <= p;
    qm  <= q;
    gm  <= g;
    @(posedge clk);
    stb <= 1'b0;
    repeat (209) @(posedge clk);
  endtask

  task automatic reset_dut();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  function automatic logic [31:0] cfg(input int c, input logic dly,
                                      input logic [11:0] dial);
    return {4'h0, dial, 13'h0, dly, 2'(c)};
  endfunction

  // travel gained per sample for dial td at multiple m
  function automatic int inc(input int c, input real m, input real td);
    real tm;
    case (c)
      0: tm = td * (0.157 + 0.668 / (m - 1.0));
      1: tm = td * (0.180 + 5.95 / (m * m - 1.0));
      2: tm = td * (0.0963 + 3.88 / (m * m - 1.0));
      default: tm = td * (0.0352 + 5.67 / (m * m - 1.0));
    endcase
    return int'(16777216.0 / (960.0 * tm));
  endfunction

  initial begin
    int          i;
    int          e;
    int          d0;
    int          d1;
    logic [15:0] m;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 9; i++) begin
      e = (i < 3) ? FULL : 0;
      rd(8'(i * 4), e, ALL, 0);
    end
    apb(1'b0, 8'h24, 32'h0, '{exp: 0, msk: ALL, tol: 0, err: 1'b1});
    apb(1'b1, 8'h24, 32'h5, '{exp: 0, msk: 0, tol: 0, err: 1'b1});
    wr(8'h10, 32'h0000007F);
    rd(8'h10, 32'h7F, ALL, 0);
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      reset_dut();
      wr(8'h00, cfg(i, 1'b0, 12'h100));
      m = 16'h0180 + (16'($random(seed)) & 16'h07FF);
      samp(m, 16'h0100, 16'($random(seed)) & 16'h00FF);
      e = inc(i, m / 256.0, 1.0);
      rd(8'h18, e, ALL, e / 100 + 2);
      rd(8'h1C, 0, ALL, 0);
      rd(8'h20, 0, ALL, 0);
    end
    $display("test curves done");
    reset_dut();
    wr(8'h00, cfg(0, 1'b0, 12'h010));
    wr(8'h04, cfg(0, 1'b1, 12'h010));
    repeat (48) samp(16'h0200, 16'h0200, 16'h0080);
    chk(trip, 3'b000, "early trip");
    repeat (3) samp(16'h0200, 16'h0200, 16'h0080);
    chk(trip, 3'b011, "no trip");
    chk(irq, 1'b0, "irq while masked");
    wr(8'h10, 32'h0000007F);
    @(negedge clk);
    chk(irq, 1'b1, "irq missing");
    rd(8'h0C, 32'h3, 32'h7, 0);
    @(negedge clk);
    chk(irq, 1'b0, "irq after clear");
    $display("test trip done");
    // deep reset: travel 0.0625 s dial, current 0 then 0.5
    d0 = int'(16777216.0 * 0.949 / 60.0);
    d1 = int'(16777216.0 * (0.949 - 0.936 * 0.5) / 60.0);
    samp(16'h0080, 16'h0000, 16'h0080);
    chk(trip, 3'b001, "reset start");
    rd(8'h18, FULL, ALL, 0);
    rd(8'h1C, FULL - d0, ALL, d0 / 50);
    repeat (15) samp(16'h0080, 16'h0080, 16'h0080);
    chk(trip, 3'b000, "reset end");
    rd(8'h18, 0, ALL, 0);
    rd(8'h1C, FULL - d0 - 15 * d1, ALL, d1 / 3);
    rd(8'h0C, 32'h8, 32'h8, 0);
    $display("test reset done");
    @(posedge clk);
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    repeat (3) @(posedge clk);
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    repeat (210) @(posedge clk);
    @(negedge clk);
    chk(irq, 1'b1, "no overrun irq");
    rd(8'h0C, 32'h40, 32'h40, 0);
    $display("test overrun done");
    // a strobe while the enable is low must leave travel alone
    @(posedge clk);
    ce  <= 1'b0;
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    repeat (2) @(posedge clk);
    ce  <= 1'b1;
    repeat (210) @(posedge clk);
    rd(8'h1C, FULL - d0 - 16 * d1, ALL, d1 / 3);
    rd(8'h0C, 32'h0, ALL, 0);
    $display("test enable done");
    repeat (4) @(posedge clk);
    if (notes.size() != 0) begin
      fail("notes left over");
    end
    wrap_up();
  end
endmodule // tb_itot_timer
